// >>> dv/ldss_host_model.sv
// Host model that drives the enable and dimming levels
`timescale 1ns/1ps
`default_nettype none
module ldss_host_model (
   input wire logic clk_i,
   output logic enable_o,
   output logic dim_o
);
   ////////////////////////////////////////
   // Host starts disabled with dimming high
   initial begin
      enable_o = 1'b0;
      dim_o = 1'b1;
   end
   // levels change after a falling edge
   task drive(input logic en, input logic dim);
      @(negedge clk_i);
      enable_o = en;
      dim_o = dim;
   endtask : drive
endmodule : ldss_host_model
`default_nettype wire

// >>> dv/ldss_sequencer_asserts.sv
// Port checks of the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module ldss_sequencer_asserts #(
   parameter int unsigned NUM_STRINGS = 4,
   parameter int unsigned DETECT_CYCLES = 20
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic regulator_ok_i,
   input wire logic gate_supply_ok_i,
   input wire logic over_temperature_shutdown_i,
   input wire logic ext_softstart_done_i,
   input wire logic over_voltage_i,
   input wire logic [NUM_STRINGS-1:0] sink_en_o,
   input wire logic [NUM_STRINGS-1:0] string_unused_o,
   input wire logic [ldss_pkg::SS_LEVEL_W-1:0] softstart_level_o,
   input wire logic switch_gate_drive_out_o,
   input wire logic fault_out_n_o,
   input wire logic fault_out_n_oe_o,
   input wire logic [2:0] state_o
);
   ////////////////////////////////////////
   // State and condition shorthands
   wire logic s_off = state_o == ldss_pkg::LDSS_SHUTDOWN;
   wire logic s_sus = state_o == ldss_pkg::LDSS_SUSPEND;
   wire logic s_det = state_o == ldss_pkg::LDSS_DETECT;
   wire logic s_ss = state_o == ldss_pkg::LDSS_SOFTSTART;
   wire logic s_sb = state_o == ldss_pkg::LDSS_STANDBY;
   wire logic s_run = state_o == ldss_pkg::LDSS_RUN;
   wire logic s_th = state_o == ldss_pkg::LDSS_THERMAL;
   wire logic hot = over_temperature_shutdown_i;
   wire logic low = !(regulator_ok_i && gate_supply_ok_i);
   int unsigned det_cnt_q;
   // Cycles spent in string detection
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         det_cnt_q <= 0;
      end else begin
         det_cnt_q <= s_det ? det_cnt_q + 1 : 0;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_shut; !enable_i |=> s_off; endproperty
   a_shut: assert property (p_shut) else $error("enable low kept running");
   property p_susp; enable_i && low && !hot |=> s_sus; endproperty
   a_susp: assert property (p_susp) else $error("supply low not suspended");
   property p_therm; enable_i && hot && !s_off |=> s_th; endproperty
   a_therm: assert property (p_therm) else $error("hot but no thermal off");
   property p_latch; (s_th && gate_supply_ok_i) ##1 (s_sus && gate_supply_ok_i) |-> fault_out_n_oe_o; endproperty
   a_latch: assert property (p_latch) else $error("fault not latched");
   property p_dlen; s_det ##1 s_ss |-> det_cnt_q + 1 >= DETECT_CYCLES && det_cnt_q <= DETECT_CYCLES + 1; endproperty
   a_dlen: assert property (p_dlen) else $error("detect length wrong");
   property p_hold; s_sb |-> (sink_en_o == '0 && !switch_gate_drive_out_o) ##1 (!s_sb || $stable(softstart_level_o)); endproperty
   a_hold: assert property (p_hold) else $error("standby not idle");
   property p_ss; s_run && $past(s_ss) |-> $past(ext_softstart_done_i) && &softstart_level_o; endproperty
   a_ss: assert property (p_ss) else $error("run before ramps done");
   property p_clr; s_off && $past(s_off) && $past(s_off, 2) |-> !fault_out_n_oe_o && string_unused_o == '0 && softstart_level_o == '0; endproperty
   a_clr: assert property (p_clr) else $error("shutdown kept state");
   property p_ov; s_run && enable_i && over_voltage_i |=> fault_out_n_oe_o && !fault_out_n_o; endproperty
   a_ov: assert property (p_ov) else $error("overvoltage not latched");
endmodule : ldss_sequencer_asserts
bind ldss_sequencer ldss_sequencer_asserts #(.NUM_STRINGS(NUM_STRINGS), .DETECT_CYCLES(DETECT_CYCLES)) u_asserts (
   .clk_i, .rst_n_i, .enable_i, .regulator_ok_i, .gate_supply_ok_i, .over_temperature_shutdown_i,
   .ext_softstart_done_i, .over_voltage_i, .sink_en_o, .string_unused_o, .softstart_level_o,
   .switch_gate_drive_out_o, .fault_out_n_o, .fault_out_n_oe_o, .state_o
);
`default_nettype wire

// >>> dv/led_driver_startup_sequencer_tb.sv
// Self-checking bench of the LED driver start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module led_driver_startup_sequencer_tb;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic reg_ok = 1'b0, gate_ok = 1'b0, hot = 1'b0, ss_done = 1'b0, ovp = 1'b0, ce = 1'b1;
   logic [3:0] gnd = 4'h0, sfault = 4'h0;
   wire logic en, dim;
   logic reg_en, osc_en, gate, flt_n, flt_oe;
   logic [3:0] pull, sink, unused;
   logic [11:0] lvl, lv;
   logic [2:0] st, prev = 3'h0;
   logic [2:0] exp_q[$];
   int failures = 0, checked = 0, seed = 40662, cyc = 0;
   // Open-drain fault pin with its pull-up
   wire logic flt_pin = flt_oe ? flt_n : 1'b1;
   ////////////////////////////////////////
   // Free-running 125 MHz clock
   initial forever #4 clk_i = ~clk_i;
   // Host model and design under test
   ldss_host_model host (.clk_i(clk_i), .enable_o(en), .dim_o(dim));
   ldss_sequencer #(.DETECT_CYCLES(20), .SS_SWITCH_PERIODS(8), .SW_PERIOD(16'h000a)) uut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .enable_i(en),
      .regulator_ok_i(reg_ok), .gate_supply_ok_i(gate_ok), .dim_pwm_in_i(dim),
      .over_temperature_shutdown_i(hot), .boost_sync_clock_in_i(1'b0),
      .ext_softstart_done_i(ss_done), .sink_grounded_i(gnd), .string_fault_i(sfault),
      .over_voltage_i(ovp), .internal_regulator_en_o(reg_en), .reference_osc_en_o(osc_en),
      .sink_pullup_en_o(pull), .sink_en_o(sink), .string_unused_o(unused),
      .ext_softstart_charge_o(), .softstart_level_o(lvl), .switch_gate_drive_out_o(gate),
      .fault_out_n_o(flt_n), .fault_out_n_oe_o(flt_oe), .state_o(st)
   );
   // Compare one value with its expectation
   task check(input logic [11:0] seen, input logic [11:0] want);
      checked++;
      if (seen !== want) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask : check
   // Print the counts and the verdict
   task test_done();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   // Wait a number of falling edges
   task idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask : idle
   // Note the next state, then wait for it under a bound
   task go(input logic [2:0] s);
      int n;
      n = 0;
      exp_q.push_back(s);
      while (st !== s && n < 400) begin
         @(negedge clk_i);
         n++;
      end
   endtask : go
   // Cycle ceiling, and each new state checked against the oldest note
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 6000) begin
         failures++;
         test_done();
      end
      if (rst_n_i && st !== prev) begin
         prev <= st;
         check(12'(st), exp_q.size() > 0 ? 12'(exp_q.pop_front()) : 12'hfff);
      end
   end
   initial begin
      idle(5);
      rst_n_i = 1'b1;
      gnd = 4'($random(seed));
      // supplies come up one at a time
      host.drive(1'b1, 1'b1);
      go(ldss_pkg::LDSS_SUSPEND);
      reg_ok = 1'b1;
      idle(3);
      check(12'({st, reg_en, osc_en}), 12'h007);
      gate_ok = 1'b1;
      go(ldss_pkg::LDSS_DETECT);
      check(12'(pull), 12'h00f);
      go(ldss_pkg::LDSS_SOFTSTART);
      idle(40);
      check(12'({unused, sink}), {4'h0, gnd, ~gnd});
      $display("detect test done");
      host.drive(1'b1, 1'b0);
      go(ldss_pkg::LDSS_STANDBY);
      lv = lvl;
      idle(4'($random(seed)) + 2);
      check(12'({lvl != lv, gate, sink}), 12'h000);
      host.drive(1'b1, 1'b1);
      go(ldss_pkg::LDSS_SOFTSTART);
      idle(1);
      check(12'(lvl >= lv && lv > 0), 12'h001);
      idle(150);
      check(12'(st), 12'(ldss_pkg::LDSS_SOFTSTART));
      ss_done = 1'b1;
      go(ldss_pkg::LDSS_RUN);
      check(lvl, ldss_pkg::SS_LEVEL_FULL);
      $display("soft-start test done");
      hot = 1'b1;
      go(ldss_pkg::LDSS_THERMAL);
      idle(1);
      check(12'({flt_pin, gate, sink}), 12'h000);
      hot = 1'b0;
      go(ldss_pkg::LDSS_SUSPEND);
      go(ldss_pkg::LDSS_DETECT);
      check(12'(flt_pin), 12'h000);
      go(ldss_pkg::LDSS_SOFTSTART);
      $display("thermal test done");
      host.drive(1'b0, 1'b1);
      go(ldss_pkg::LDSS_SHUTDOWN);
      idle(2);
      check(12'({!flt_pin, unused, lvl != 12'h000}), 12'h000);
      // Clock enable low freezes the sequencer in shutdown
      ce = 1'b0;
      host.drive(1'b1, 1'b1);
      idle(3);
      check(12'({st, reg_en}), 12'h000);
      ce = 1'b1;
      // timer length, overvoltage latch, gate supply clear
      go(ldss_pkg::LDSS_SUSPEND);
      go(ldss_pkg::LDSS_DETECT);
      go(ldss_pkg::LDSS_SOFTSTART);
      idle(60);
      check(12'(st), 12'(ldss_pkg::LDSS_SOFTSTART));
      go(ldss_pkg::LDSS_RUN);
      // a faulty active string is latched off and flags the fault
      sfault = ~gnd;
      idle(1);
      sfault = 4'h0;
      idle(2);
      check(12'({sink, flt_pin}), {7'h00, 4'h0, gnd == 4'hf});
      ovp = 1'b1;
      idle(1);
      ovp = 1'b0;
      idle(2);
      check(12'(flt_pin), 12'h000);
      gate_ok = 1'b0;
      go(ldss_pkg::LDSS_SUSPEND);
      idle(1);
      check(12'(flt_pin), 12'h001);
      check(12'(exp_q.size()), 12'h000);
      $display("fault test done");
      test_done();
   end
endmodule : led_driver_startup_sequencer_tb
`default_nettype wire

// >>> hdl/ldss_pkg.sv
// Shared constants and types for the LED driver start-up sequencer
package ldss_pkg;
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned NUM_STRINGS = 4;
   // Unused-string detection time, microseconds, and its cycle count
   localparam int unsigned DETECT_TIME_US = 1000;
   localparam int unsigned DETECT_CYCLES = DETECT_TIME_US * CLK_MHZ;
   // Internal soft-start length counted in boost switching periods (4 ms at 1 MHz)
   localparam int unsigned SS_SWITCH_PERIODS = 4000;
   // Width of the retained soft-start level
   localparam int unsigned SS_LEVEL_W = 12;
   localparam logic [11:0] SS_LEVEL_FULL = 12'hfff;
   localparam logic [11:0] SS_LEVEL_RESET = 12'h000;
   // Boost period in clock cycles with no external sync (1 MHz free run)
   localparam int unsigned SW_PERIOD_DEFAULT = 125;
   localparam int unsigned SW_PERIOD_W = 16;
   localparam logic [15:0] SW_ON_CYCLES = 16'h0020;

   // Gray codes along shutdown, suspend, detect, soft-start, run
   typedef enum logic [2:0] {
      LDSS_SHUTDOWN  = 3'b000,
      LDSS_SUSPEND   = 3'b001,
      LDSS_DETECT    = 3'b011,
      LDSS_SOFTSTART = 3'b010,
      LDSS_RUN       = 3'b110,
      LDSS_STANDBY   = 3'b111,
      LDSS_THERMAL   = 3'b100
   } ldss_state_e;
endpackage : ldss_pkg

// >>> hdl/ldss_sequencer.sv
// Power-state sequencer of a four-string LED backlight driver
`timescale 1ns/1ps
`default_nettype none
module ldss_sequencer #(
   parameter int unsigned NUM_STRINGS = ldss_pkg::NUM_STRINGS,
   parameter int unsigned DETECT_CYCLES = ldss_pkg::DETECT_CYCLES,
   parameter int unsigned SS_SWITCH_PERIODS = ldss_pkg::SS_SWITCH_PERIODS,
   parameter logic [15:0] SW_PERIOD = 16'(ldss_pkg::SW_PERIOD_DEFAULT)
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic enable_i,
   input wire logic regulator_ok_i,
   input wire logic gate_supply_ok_i,
   input wire logic dim_pwm_in_i,
   input wire logic over_temperature_shutdown_i,
   input wire logic boost_sync_clock_in_i,
   input wire logic ext_softstart_done_i,
   input wire logic [NUM_STRINGS-1:0] sink_grounded_i,
   input wire logic [NUM_STRINGS-1:0] string_fault_i,
   input wire logic over_voltage_i,
   output logic internal_regulator_en_o,
   output logic reference_osc_en_o,
   output logic [NUM_STRINGS-1:0] sink_pullup_en_o,
   output logic [NUM_STRINGS-1:0] sink_en_o,
   output logic [NUM_STRINGS-1:0] string_unused_o,
   output logic ext_softstart_charge_o,
   output logic [ldss_pkg::SS_LEVEL_W-1:0] softstart_level_o,
   output logic switch_gate_drive_out_o,
   output logic fault_out_n_o,
   output logic fault_out_n_oe_o,
   output logic [2:0] state_o
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   localparam int unsigned DET_W = $clog2(DETECT_CYCLES + 1);
   localparam int unsigned SSP_W = $clog2(SS_SWITCH_PERIODS + 1);

   ldss_pkg::ldss_state_e state_q;
   ldss_pkg::ldss_state_e state_d;
   logic [DET_W-1:0] det_cnt_q;
   logic [SSP_W-1:0] ss_cnt_q;
   logic [ldss_pkg::SS_LEVEL_W-1:0] ss_level_q;
   logic int_ss_done;
   logic ss_done;
   logic [NUM_STRINGS-1:0] unused_q;
   logic [NUM_STRINGS-1:0] latched_off_q;
   logic fault_q;
   logic gate_supply_q;
   logic supplies_ok;
   logic det_done;
   logic sinks_on;
   logic [NUM_STRINGS-1:0] unused_d;

   ldss_sw_if sw_bus ();

   ////////////////////////////////////////////////////////////////////////////
   // Switching clock generator
   ldss_switch_clk #(
      .PERIOD(SW_PERIOD)
   ) u_switch_clk (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .sync_i(boost_sync_clock_in_i),
      .sw(sw_bus.gen)
   );

   assign supplies_ok = regulator_ok_i & gate_supply_ok_i;
   assign det_done = (det_cnt_q >= DET_W'(DETECT_CYCLES - 1));
   assign int_ss_done = (ss_cnt_q >= SSP_W'(SS_SWITCH_PERIODS));
   assign ss_done = int_ss_done & ext_softstart_done_i;
   assign sw_bus.run = (state_q == ldss_pkg::LDSS_SOFTSTART) ||
      (state_q == ldss_pkg::LDSS_RUN);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ldss_pkg::LDSS_SHUTDOWN: begin
            if (enable_i) begin
               state_d = ldss_pkg::LDSS_SUSPEND;
            end
         end
         ldss_pkg::LDSS_SUSPEND: begin
            if (supplies_ok) begin
               state_d = ldss_pkg::LDSS_DETECT;
            end
         end
         ldss_pkg::LDSS_DETECT: begin
            if (det_done) begin
               state_d = ldss_pkg::LDSS_SOFTSTART;
            end
         end
         ldss_pkg::LDSS_SOFTSTART: begin
            if (!dim_pwm_in_i) begin
               state_d = ldss_pkg::LDSS_STANDBY;
            end else if (ss_done) begin
               state_d = ldss_pkg::LDSS_RUN;
            end
         end
         ldss_pkg::LDSS_STANDBY: begin
            if (dim_pwm_in_i) begin
               state_d = ldss_pkg::LDSS_SOFTSTART;
            end
         end
         ldss_pkg::LDSS_RUN: begin
            state_d = ldss_pkg::LDSS_RUN;
         end
         ldss_pkg::LDSS_THERMAL: begin
            if (!over_temperature_shutdown_i) begin
               state_d = ldss_pkg::LDSS_SUSPEND;
            end
         end
         default: begin
            state_d = ldss_pkg::LDSS_SHUTDOWN;
         end
      endcase
      if (state_q != ldss_pkg::LDSS_SHUTDOWN && over_temperature_shutdown_i) begin
         state_d = ldss_pkg::LDSS_THERMAL;
      end
      else if (state_q != ldss_pkg::LDSS_SHUTDOWN && state_q != ldss_pkg::LDSS_THERMAL
            && !supplies_ok) begin
         state_d = ldss_pkg::LDSS_SUSPEND;
      end
      if (!enable_i) begin
         state_d = ldss_pkg::LDSS_SHUTDOWN;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_q <= ldss_pkg::LDSS_SHUTDOWN;
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Detection timer
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         det_cnt_q <= '0;
      end else if (ce_i) begin
         if (state_q == ldss_pkg::LDSS_DETECT && !det_done) begin
            det_cnt_q <= det_cnt_q + DET_W'(1);
         end else if (state_q != ldss_pkg::LDSS_DETECT) begin
            det_cnt_q <= '0;
         end
      end
   end

   // Unused-string results, one per string
   for (genvar g = 0; g < NUM_STRINGS; g++) begin : g_string
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            unused_q[g] <= 1'b0;
            latched_off_q[g] <= 1'b0;
         end else if (ce_i) begin
            if (state_q == ldss_pkg::LDSS_SHUTDOWN) begin
               unused_q[g] <= 1'b0;
               latched_off_q[g] <= 1'b0;
            end else begin
               if (state_q == ldss_pkg::LDSS_DETECT && det_done) begin
                  unused_q[g] <= sink_grounded_i[g];
               end
               // faulty string latched off, released by a gate supply cycle
               if (string_fault_i[g] && !unused_q[g] && sinks_on) begin
                  latched_off_q[g] <= 1'b1;
               end else if (gate_supply_q && !gate_supply_ok_i) begin
                  latched_off_q[g] <= 1'b0;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Internal soft-start timer and retained level
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ss_cnt_q <= '0;
         ss_level_q <= ldss_pkg::SS_LEVEL_RESET;
      end else if (ce_i) begin
         if (state_q == ldss_pkg::LDSS_SHUTDOWN || state_q == ldss_pkg::LDSS_SUSPEND
               || state_q == ldss_pkg::LDSS_THERMAL) begin
            ss_cnt_q <= '0;
            ss_level_q <= ldss_pkg::SS_LEVEL_RESET;
         end else if (state_q == ldss_pkg::LDSS_RUN) begin
            ss_level_q <= ldss_pkg::SS_LEVEL_FULL;
         end
         // timer stops at the edge that leaves the ramp, resumes here
         else if (state_q == ldss_pkg::LDSS_SOFTSTART && state_d == ldss_pkg::LDSS_SOFTSTART
               && sw_bus.sw_tick && !int_ss_done) begin
            ss_cnt_q <= ss_cnt_q + SSP_W'(1);
            ss_level_q <= ldss_pkg::SS_LEVEL_W'(((ss_cnt_q + 1) * 32'(ldss_pkg::SS_LEVEL_FULL))
               / SS_SWITCH_PERIODS);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault latch, cleared only by shutdown or gate supply cycling
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fault_q <= 1'b0;
         gate_supply_q <= 1'b0;
      end else if (ce_i) begin
         gate_supply_q <= gate_supply_ok_i;
         if (over_temperature_shutdown_i && state_q != ldss_pkg::LDSS_SHUTDOWN) begin
            fault_q <= 1'b1;
         end else if (over_voltage_i && sinks_on) begin
            fault_q <= 1'b1;
         end else if (|(string_fault_i & ~unused_q) && sinks_on) begin
            fault_q <= 1'b1;
         end
         // enable or gate supply cycle clears
         else if (state_q == ldss_pkg::LDSS_SHUTDOWN || (gate_supply_q && !gate_supply_ok_i)) begin
            fault_q <= 1'b0;
         end
      end
   end

   assign sinks_on = (state_q == ldss_pkg::LDSS_SOFTSTART) || (state_q == ldss_pkg::LDSS_RUN);
   // result as it stands after this edge, so a grounded string never lights
   assign unused_d = (state_q == ldss_pkg::LDSS_DETECT && det_done) ? sink_grounded_i
      : unused_q;

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         internal_regulator_en_o <= 1'b0;
         reference_osc_en_o <= 1'b0;
         sink_pullup_en_o <= '0;
         sink_en_o <= '0;
         string_unused_o <= '0;
         ext_softstart_charge_o <= 1'b0;
         softstart_level_o <= ldss_pkg::SS_LEVEL_RESET;
         switch_gate_drive_out_o <= 1'b0;
         fault_out_n_o <= 1'b0;
         fault_out_n_oe_o <= 1'b0;
         state_o <= 3'h0;
      end else if (ce_i) begin
         internal_regulator_en_o <= (state_d != ldss_pkg::LDSS_SHUTDOWN);
         reference_osc_en_o <= (state_d != ldss_pkg::LDSS_SHUTDOWN);
         sink_pullup_en_o <= {NUM_STRINGS{state_d == ldss_pkg::LDSS_DETECT}};
         // sinks off outside ramp and run
         sink_en_o <= (state_d == ldss_pkg::LDSS_SOFTSTART || state_d == ldss_pkg::LDSS_RUN)
            ? ~(unused_d | latched_off_q) : '0;
         string_unused_o <= unused_q;
         ext_softstart_charge_o <= (state_d == ldss_pkg::LDSS_SOFTSTART);
         softstart_level_o <= ss_level_q;
         // drive off at once in standby
         switch_gate_drive_out_o <= sw_bus.gate && (state_d == ldss_pkg::LDSS_SOFTSTART
            || state_d == ldss_pkg::LDSS_RUN) && !over_voltage_i;
         fault_out_n_o <= 1'b0;
         fault_out_n_oe_o <= fault_q;
         state_o <= state_d;
      end
   end
endmodule : ldss_sequencer
`default_nettype wire

// >>> hdl/ldss_sw_if.sv
// Boost switching clock signals shared between sequencer and clock generator
`timescale 1ns/1ps
`default_nettype none
interface ldss_sw_if;
   logic run;
   logic sw_tick;
   logic gate;
   modport gen (input run, output sw_tick, output gate);
   modport seq (output run, input sw_tick, input gate);
endinterface : ldss_sw_if
`default_nettype wire

// >>> hdl/ldss_switch_clk.sv
// Boost switching clock: free-running period, aligned to sync rising edges
`timescale 1ns/1ps
`default_nettype none
module ldss_switch_clk #(
   parameter logic [15:0] PERIOD = 16'(ldss_pkg::SW_PERIOD_DEFAULT)
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic sync_i,
   ldss_sw_if.gen sw
);
   logic [15:0] cnt_q;
   logic sync_q;
   logic sync_rise;

   assign sync_rise = sync_i & ~sync_q;

   // Sync edge history
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sync_q <= 1'b0;
      end else if (ce_i) begin
         sync_q <= sync_i;
      end
   end

   // Period counter, restarted by a sync rising edge
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_q <= 16'h0000;
         sw.sw_tick <= 1'b0;
         sw.gate <= 1'b0;
      end else if (ce_i) begin
         if (sync_rise || cnt_q >= PERIOD - 16'h0001) begin
            cnt_q <= 16'h0000;
            sw.sw_tick <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
            sw.sw_tick <= 1'b0;
         end
         sw.gate <= sw.run && (sync_rise || cnt_q >= PERIOD - 16'h0001 ||
            (cnt_q + 16'h0001) < ldss_pkg::SW_ON_CYCLES);
      end
   end
endmodule : ldss_switch_clk
`default_nettype wire
